// *** hdl/ilp_level_mask.sv ***
// Level masking, source mask and prioritisation of one interrupt controller
//
// The placing of the registers and strobed register access were chosen for this implementation.
`include "ilp_params.svh"
`default_nettype none
module ilp_level_mask #(
    parameter bit IS_FIRST_SPACE = 1'b1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [7:0] regRdData,
    input wire logic maskSetStb,
    input wire logic [7:0] maskSetData,
    input wire logic [63:0] srcReq,
    input wire logic [3:0] sharedLimitIn,
    output logic [3:0] curLimitOut,
    output logic irqReq,
    output logic [2:0] irqLevel
);

    logic [63:0] maskFf;
    logic [63:0] pendFf;
    logic [2:0] levelFf [0:63];
    ilp_pkg::ilp_limit_t curLimitFf;
    ilp_pkg::ilp_limit_t savedLimitFf;
    logic emaskFf;
    logic [7:0] rdDataFf;
    logic irqReqFf;
    ilp_pkg::ilp_level_t irqLevelFf;

    logic [7:0] nxt_rdData;
    logic [63:0] nxt_mask;
    ilp_pkg::ilp_level_vec_t levelVec;
    ilp_pkg::ilp_limit_t effLimit;
    logic [63:0] eligible;
    logic found;
    ilp_pkg::ilp_src_t winSrc;
    ilp_pkg::ilp_level_t winLevel;
    logic wrLevel;
    logic wrMaskByte;
    logic wrClear;
    logic wrCurLimit;
    logic wrSavedLimit;
    logic wrConfig;
    logic ackRead;
    logic autoLoad;

    // Reserved limit codes 1000..1110 are treated like 1111: nothing blocked
    function automatic logic levelPasses(input ilp_pkg::ilp_level_t lvl, input ilp_pkg::ilp_limit_t lim);
        ilp_pkg::ilp_level_t floorLvl;
        floorLvl = lim[`ILP_LIMIT_RSV_BIT] ? `ILP_LEVEL_NONE : lim[`ILP_LEVEL_MSB:0];
        return lvl > floorLvl;
    endfunction

    function automatic logic [7:0] byteOf(input logic [63:0] word, input logic [2:0] sel);
        return word[{sel, 3'h0} +: 8];
    endfunction

    // Address decode
    assign wrLevel = regWrStb && (regAddr[7:6] == `ILP_GRP_LEVEL);
    assign wrMaskByte = regWrStb && (regAddr[7:3] == `ILP_GRP_MASK);
    assign wrClear = regWrStb && (regAddr == `ILP_ADDR_MASK_CLEAR);
    assign wrCurLimit = regWrStb && (regAddr == `ILP_ADDR_CUR_LIMIT) && IS_FIRST_SPACE;
    assign wrSavedLimit = regWrStb && (regAddr == `ILP_ADDR_SAVED_LIMIT) && IS_FIRST_SPACE;
    assign wrConfig = regWrStb && (regAddr == `ILP_ADDR_CONFIG);
    assign ackRead = regRdStb && (regAddr == `ILP_ADDR_ACK);
    assign autoLoad = ackRead && emaskFf && found && IS_FIRST_SPACE;

    // Other instances follow the single limit held by the first space
    assign effLimit = IS_FIRST_SPACE ? curLimitFf : sharedLimitIn;

    // Source levels
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 64; i++) begin
                levelFf[i] <= `ILP_LEVEL_RESET;
            end
        end else if (wrLevel) begin
            levelFf[regAddr[`ILP_SRC_MSB:0]] <= regWrData[`ILP_LEVEL_MSB:0];
        end
    end

    always_comb begin
        for (int i = 0; i < 64; i++) begin
            levelVec[i] = levelFf[i];
        end
    end

    // Pending bits follow the request lines every clock, mask or not
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pendFf <= `ILP_MASK_NONE;
        end else begin
            pendFf <= srcReq;
            if (IS_FIRST_SPACE) begin
                pendFf[`ILP_UNUSED_SRC] <= 1'b0;
            end
        end
    end

    // Mask update: byte write, then clear port, then set port so set wins
    always_comb begin
        nxt_mask = maskFf;
        if (wrMaskByte) begin
            nxt_mask[{regAddr[`ILP_BYTE_SEL_MSB:0], 3'h0} +: 8] = regWrData;
        end
        if (wrClear) begin
            if (regWrData[`ILP_ALL_BIT]) begin
                nxt_mask = `ILP_MASK_NONE;
            end else begin
                nxt_mask[regWrData[`ILP_SRC_MSB:0]] = 1'b0;
            end
        end
        if (maskSetStb) begin
            if (maskSetData[`ILP_ALL_BIT]) begin
                nxt_mask = `ILP_MASK_RESET;
            end else begin
                nxt_mask[maskSetData[`ILP_SRC_MSB:0]] = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            maskFf <= `ILP_MASK_RESET;
        end else begin
            maskFf <= nxt_mask;
        end
    end

    // Configuration: only the auto masking enable is kept
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            emaskFf <= 1'b0;
        end else if (wrConfig) begin
            emaskFf <= regWrData[`ILP_AUTO_LEVEL_MASKING_ENABLE_BIT];
        end
    end

    // Current limit: software load or acknowledge load
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            curLimitFf <= `ILP_LIMIT_RESET;
        end else if (autoLoad) begin
            curLimitFf <= {1'b0, winLevel};
        end else if (wrCurLimit) begin
            curLimitFf <= regWrData[`ILP_LIMIT_MSB:0];
        end
    end

    // Saved limit takes the old current value on the same edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            savedLimitFf <= `ILP_LIMIT_RESET;
        end else if (autoLoad) begin
            savedLimitFf <= curLimitFf;
        end else if (wrSavedLimit) begin
            savedLimitFf <= regWrData[`ILP_LIMIT_MSB:0];
        end
    end

    // Qualifying requests
    always_comb begin
        for (int i = 0; i < 64; i++) begin
            eligible[i] = pendFf[i] && !maskFf[i] && levelPasses(levelVec[i], effLimit);
        end
    end

    ilp_prio_pick u_pick (
        .eligible(eligible),
        .levels(levelVec),
        .found(found),
        .srcNum(winSrc),
        .srcLevel(winLevel)
    );

    // Registered request to the core; one cycle behind the qualifying set
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irqReqFf <= 1'b0;
            irqLevelFf <= `ILP_LEVEL_NONE;
        end else begin
            irqReqFf <= found;
            irqLevelFf <= found ? winLevel : `ILP_LEVEL_NONE;
        end
    end

    // Read data, valid only in the cycle after the strobe
    always_comb begin
        nxt_rdData = `ILP_READ_ZERO;
        if (regRdStb) begin
            if (regAddr[7:6] == `ILP_GRP_LEVEL) begin
                nxt_rdData = {5'h00, levelFf[regAddr[`ILP_SRC_MSB:0]]};
            end else if (regAddr[7:3] == `ILP_GRP_MASK) begin
                nxt_rdData = byteOf(maskFf, regAddr[`ILP_BYTE_SEL_MSB:0]);
            end else if (regAddr[7:3] == `ILP_GRP_PEND) begin
                nxt_rdData = byteOf(pendFf, regAddr[`ILP_BYTE_SEL_MSB:0]);
            end else if (regAddr == `ILP_ADDR_MASK_CLEAR) begin
                nxt_rdData = `ILP_READ_ZERO;
            end else if (regAddr == `ILP_ADDR_CUR_LIMIT && IS_FIRST_SPACE) begin
                nxt_rdData = {4'h0, curLimitFf};
            end else if (regAddr == `ILP_ADDR_SAVED_LIMIT && IS_FIRST_SPACE) begin
                nxt_rdData = {4'h0, savedLimitFf};
            end else if (regAddr == `ILP_ADDR_CONFIG) begin
                nxt_rdData = {2'h0, emaskFf, 5'h00};
            end else if (regAddr == `ILP_ADDR_ACK) begin
                // Vector is the physical source number; no winner reads as a spurious code
                nxt_rdData = found ? {2'h0, winSrc} : `ILP_NO_VECTOR;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdDataFf <= `ILP_READ_ZERO;
        end else begin
            rdDataFf <= nxt_rdData;
        end
    end

    assign regRdData = rdDataFf;
    assign curLimitOut = curLimitFf;
    assign irqReq = irqReqFf;
    assign irqLevel = irqLevelFf;

endmodule
`default_nettype wire

// *** hdl/ilp_params.svh ***
// Address map, field positions and reset values of the level-mask and priority block
// How it works
// - Clear-field write clears that source's mask bit
// - Clear-all bit clears whole mask, field ignored
// - Clear-mask port always reads zero
// - Simultaneous set and clear: set wins
// - Auto-mask acknowledge returns source, loads current limit
// - Levels at or below limit 0..7 never raise interrupt
// - Auto-mask acknowledge copies old current limit into saved
// - Limit encoding: 0 or 15 pass all, 7 blocks
// - Single limit pair lives in first controller space
// - Saved limit is 4 bits, same encoding
// - Sixty-four 3-bit source levels, reset to zero
// - Equal levels: highest source number served first
// - Level 0 never requests, level 7 highest
// - First controller: source 0 unused, others wired
// - Auto masking only while config bit 5 set
// - Mask resets all ones, one disables source
// - Pending samples request every clock, ignoring mask
`ifndef ILP_PARAMS_SVH
`define ILP_PARAMS_SVH

`define ILP_ADDR_MASK_CLEAR 8'h40
`define ILP_ADDR_CUR_LIMIT 8'h42
`define ILP_ADDR_SAVED_LIMIT 8'h43
`define ILP_ADDR_CONFIG 8'h44
`define ILP_ADDR_ACK 8'h60
`define ILP_GRP_LEVEL 2'h0
`define ILP_GRP_MASK 5'h09
`define ILP_GRP_PEND 5'h0A

`define ILP_ALL_BIT 6
`define ILP_SRC_MSB 5
`define ILP_LEVEL_MSB 2
`define ILP_LIMIT_MSB 3
`define ILP_LIMIT_RSV_BIT 3
`define ILP_AUTO_LEVEL_MASKING_ENABLE_BIT 5
`define ILP_BYTE_SEL_MSB 2

`define ILP_MASK_RESET 64'hFFFF_FFFF_FFFF_FFFF
`define ILP_MASK_NONE 64'h0000_0000_0000_0000
`define ILP_LIMIT_RESET 4'h0
`define ILP_LEVEL_RESET 3'h0
`define ILP_LEVEL_NONE 3'h0
`define ILP_NO_VECTOR 8'h80
`define ILP_READ_ZERO 8'h00
`define ILP_UNUSED_SRC 6'h00

`endif

// *** hdl/ilp_pkg.sv ***
// Types shared by the level-mask and priority block
`default_nettype none
package ilp_pkg;
    typedef logic [2:0] ilp_level_t;
    typedef logic [3:0] ilp_limit_t;
    typedef logic [5:0] ilp_src_t;
    typedef logic [63:0][2:0] ilp_level_vec_t;
endpackage
`default_nettype wire

// *** hdl/ilp_prio_pick.sv ***
// Priority picker: highest level, then highest source number
`default_nettype none
module ilp_prio_pick (
    input wire logic [63:0] eligible,
    input wire ilp_pkg::ilp_level_vec_t levels,
    output var logic found,
    output var ilp_pkg::ilp_src_t srcNum,
    output var ilp_pkg::ilp_level_t srcLevel
);
    // Ascending scan with >= lets a later, higher-numbered source win a tie
    always_comb begin
        found = 1'b0;
        srcNum = '0;
        srcLevel = '0;
        for (int i = 0; i < 64; i++) begin
            if (eligible[i] && (levels[i] >= srcLevel)) begin
                found = 1'b1;
                srcNum = ilp_pkg::ilp_src_t'(i);
                srcLevel = levels[i];
            end
        end
    end
endmodule
`default_nettype wire

// *** verification/ilp_level_mask_props.sv ***
// Port-level assertions for the level-mask and priority block
`include "ilp_params.svh"
`default_nettype none
module ilp_level_mask_props (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    input wire logic [7:0] regRdData,
    input wire logic [63:0] srcReq,
    input wire logic [3:0] curLimitOut,
    input wire logic irqReq,
    input wire logic [2:0] irqLevel
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    wire logic ack = regRdStb && regAddr == `ILP_ADDR_ACK;
    wire logic limWr = regWrStb && regAddr == `ILP_ADDR_CUR_LIMIT;
    property p_clr_rd; regRdStb && regAddr == `ILP_ADDR_MASK_CLEAR |=> regRdData == `ILP_READ_ZERO; endproperty
    a_clr_rd: assert property (p_clr_rd) else $error("clear port read not zero");
    property p_irq_lvl; !irqReq |-> irqLevel == 3'h0; endproperty
    a_irq_lvl: assert property (p_irq_lvl) else $error("level without request");
    // Output is registered, so it answers the limit of the previous cycle
    property p_above; irqReq && !$past(curLimitOut[3]) |-> irqLevel > $past(curLimitOut[2:0]); endproperty
    a_above: assert property (p_above) else $error("level not above limit");
    property p_lim7; curLimitOut == 4'h7 |=> !irqReq; endproperty
    a_lim7: assert property (p_lim7) else $error("limit 7 let request out");
    property p_hold; !limWr && !ack |=> $stable(curLimitOut); endproperty
    a_hold: assert property (p_hold) else $error("limit moved on its own");
    property p_lim_wr; limWr |=> curLimitOut == $past(regWrData[3:0]); endproperty
    a_lim_wr: assert property (p_lim_wr) else $error("limit write lost");
    property p_ack_none; ack ##1 regRdData == `ILP_NO_VECTOR |-> $stable(curLimitOut); endproperty
    a_ack_none: assert property (p_ack_none) else $error("empty ack loaded limit");
    property p_ack_vec; ack |=> regRdData[7:6] == 2'h0 || regRdData == `ILP_NO_VECTOR; endproperty
    a_ack_vec: assert property (p_ack_vec) else $error("bad vector");
    property p_noreq; srcReq == 64'h0 [*2] |=> !irqReq; endproperty
    a_noreq: assert property (p_noreq) else $error("request with no source");
endmodule
`default_nettype wire

// *** verification/ilp_core_model.sv ***
// Core-side model: keeps the last level offered to it
`default_nettype none
module ilp_core_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic irqReq,
    input wire logic [2:0] irqLevel,
    output logic [2:0] seenLevel
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) seenLevel <= 3'h0;
        else if (irqReq) seenLevel <= irqLevel;
    end
endmodule
`default_nettype wire

// *** verification/tb_ilp_level_mask.sv ***
// Testbench for the level-mask and priority block
`include "ilp_params.svh"
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; $display("[ERR] %0t %h/%h", $time, a, e); end end
module tb_ilp_level_mask;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, maskSetData = 8'h00, regRdData;
    logic regWrStb = 1'b0, regRdStb = 1'b0, maskSetStb = 1'b0, irqReq;
    logic [63:0] srcReq = 64'h0;
    logic [3:0] curLimitOut;
    logic [2:0] irqLevel, seenLevel;
    int errors = 0, comparisons = 0;
    always #2 mclk = ~mclk;
    // Single controller space, so the shared limit input is never used
    ilp_level_mask uut (.mclk, .rst, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData, .maskSetStb,
        .maskSetData, .srcReq, .sharedLimitIn(4'h0), .curLimitOut, .irqReq, .irqLevel);
    ilp_core_model core (.mclk, .rst, .irqReq, .irqLevel, .seenLevel);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge mclk);
        regWrStb <= 1'b0;
        // One idle edge keeps back-to-back writes from driving the strobe twice in one step
        @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge mclk);
        regRdStb <= 1'b0;
        @(negedge mclk);
        `CHK(regRdData, e)
        @(posedge mclk);
    endtask
    // Three edges cover the two-stage source path with margin
    task automatic irq(input logic r, input logic [2:0] l);
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        `CHK({irqReq, irqLevel}, {r, l})
        @(posedge mclk);
    endtask
    task automatic results();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #100000;
        errors++;
        results();
    end
    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(8'h48, 8'hFF);
        rd(8'h4F, 8'hFF);
        rd(8'h05, 8'h00);
        rd(`ILP_ADDR_CUR_LIMIT, 8'h00);
        rd(`ILP_ADDR_SAVED_LIMIT, 8'h00);
        // Levels go in before any source is unmasked
        wr(8'h05, 8'h03);
        wr(8'h09, 8'h03);
        wr(8'h14, 8'h06);
        srcReq <= 64'h4000_0220;
        irq(1'b0, 3'h0);
        rd(8'h51, 8'h02);
        wr(`ILP_ADDR_MASK_CLEAR, 8'h1E);
        irq(1'b0, 3'h0);
        wr(`ILP_ADDR_MASK_CLEAR, 8'h05);
        rd(8'h48, 8'hDF);
        irq(1'b1, 3'h3);
        rd(`ILP_ADDR_MASK_CLEAR, 8'h00);
        wr(`ILP_ADDR_MASK_CLEAR, 8'h49);
        rd(8'h49, 8'h00);
        rd(8'h4F, 8'h00);
        rd(`ILP_ADDR_ACK, 8'h09);
        rd(`ILP_ADDR_CUR_LIMIT, 8'h00);
        wr(`ILP_ADDR_CONFIG, 8'h20);
        srcReq <= 64'h4010_0220;
        irq(1'b1, 3'h6);
        rd(`ILP_ADDR_ACK, 8'h14);
        rd(`ILP_ADDR_CUR_LIMIT, 8'h06);
        rd(`ILP_ADDR_SAVED_LIMIT, 8'h00);
        irq(1'b0, 3'h0);
        wr(`ILP_ADDR_CUR_LIMIT, 8'h03);
        irq(1'b1, 3'h6);
        rd(`ILP_ADDR_ACK, 8'h14);
        rd(`ILP_ADDR_SAVED_LIMIT, 8'h03);
        wr(`ILP_ADDR_CUR_LIMIT, 8'h0F);
        irq(1'b1, 3'h6);
        wr(`ILP_ADDR_CUR_LIMIT, 8'h07);
        irq(1'b0, 3'h0);
        wr(`ILP_ADDR_CUR_LIMIT, 8'h00);
        @(negedge mclk);
        `CHK(seenLevel, 3'h6)
        `CHK(curLimitOut, 4'h0)
        @(posedge mclk);
        // Set and clear share exactly one edge, so a lost set cannot be repaired by a later edge
        maskSetData <= 8'h09;
        maskSetStb <= 1'b1;
        regAddr <= `ILP_ADDR_MASK_CLEAR;
        regWrData <= 8'h09;
        regWrStb <= 1'b1;
        @(posedge mclk);
        maskSetStb <= 1'b0;
        regWrStb <= 1'b0;
        @(posedge mclk);
        rd(8'h49, 8'h02);
        wr(8'h00, 8'h07);
        srcReq <= 64'h1;
        irq(1'b0, 3'h0);
        rd(8'h50, 8'h00);
        rd(`ILP_ADDR_ACK, `ILP_NO_VECTOR);
        rd(8'h70, 8'h00);
        results();
    end
endmodule
bind ilp_level_mask ilp_level_mask_props u_props (.mclk, .rst, .regAddr, .regWrData, .regWrStb, .regRdStb,
    .regRdData, .srcReq, .curLimitOut, .irqReq, .irqLevel);
`default_nettype wire
